// ===== core/dsmc_pkg.sv
// Package of constants, states and object map for the drive state machine controller
// What this block does
// [R01] Key on restore-all resets everything, reads 1
// [R02] Key on comm-restore resets comm group, reads 1
// [R03] Key on profile-restore resets profile group, reads 1
// [R04] Key on vendor-restore resets vendor group, reads 1
// [R05] Alarm clear needs error gone and restart
// [R06] Master disables axis, freezes gains during trial; the code refuses gain writes in a trial and a trial start while status is SW_RUNNING, not the axis
// [R07] Power-up: init 0x0000, then faultless 0x0250
// [R08] Fault while leaving init goes to fault-stop
// [R09] Word 0x0006 enters ready, status 0x0231
// [R10] Word 0x0007 enters waiting-to-enable, status 0x0233
// [R11] Word 0x000f in waiting enables, status 0x0237
// [R12] Word 0x0000 returns to faultless, status 0x0250
// [R13] Word 0x0002 quick stops; auto faultless unless 0x0f
// [R14] Fault: fault-stop 0x021f, resolved gives fault 0x0218
// [R15] Fault state leaves only on word 0x80
// [R16] Supported modes reads bits 0,2,3,5,7,8,9
// [R17] Status word reports state after every command
// [R18] Master enables, homes, then issues motion
// [R19] Invalid control word changes nothing
package dsmc_pkg;

  // ----------------------------------------------------------------
  // Object dictionary
  // ----------------------------------------------------------------
  localparam logic [15:0] OBJ_RESTORE = 16'h1011;
  localparam logic [15:0] OBJ_CTRL_WORD = 16'h6040;
  localparam logic [15:0] OBJ_STATUS_WORD = 16'h6041;
  localparam logic [15:0] OBJ_SUPPORTED_MODES = 16'h6502;
  localparam logic [15:0] OBJ_GAIN_FIRST = 16'h2000;
  localparam logic [15:0] OBJ_GAIN_LAST = 16'h20ff;
  localparam logic [31:0] RESTORE_KEY = 32'h64616f6c;
  localparam logic [31:0] SUPPORTED_MODES_VAL = 32'h0000_03ad;

  // ----------------------------------------------------------------
  // Control words and status words
  // ----------------------------------------------------------------
  localparam logic [15:0] CW_DISABLE = 16'h0000;
  localparam logic [15:0] CW_QUICK_STOP = 16'h0002;
  localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
  localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
  localparam logic [15:0] CW_ENABLE = 16'h000f;
  localparam logic [15:0] CW_FAULT_RESET = 16'h0080;
  localparam logic [15:0] SW_INIT = 16'h0000;
  localparam logic [15:0] SW_FAULTLESS = 16'h0250;
  localparam logic [15:0] SW_READY = 16'h0231;
  localparam logic [15:0] SW_WAITING = 16'h0233;
  localparam logic [15:0] SW_RUNNING = 16'h0237;
  localparam logic [15:0] SW_QUICK_STOP = 16'h0217;
  localparam logic [15:0] SW_FAULT_STOP = 16'h021f;
  localparam logic [15:0] SW_FAULT = 16'h0218;
  localparam int SW_HOMED_BIT = 12;

  // Quick stop ramp time before falling back to faultless
  localparam int QS_TIME_NS = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [7:0] QS_CYCLES = 8'(QS_TIME_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Controller register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_CTRL_WORD = 6'h00;
  localparam logic [5:0] REG_STATUS = 6'h04;
  localparam logic [5:0] REG_OBJ_ADDR = 6'h08;
  localparam logic [5:0] REG_OBJ_WDATA = 6'h0c;
  localparam logic [5:0] REG_OBJ_CMD = 6'h10;
  localparam logic [5:0] REG_OBJ_RDATA = 6'h14;
  localparam logic [5:0] REG_AUX = 6'h18;
  localparam logic [5:0] REG_FLAGS = 6'h1c;
  localparam int AUX_TRIAL_BIT = 0;
  localparam int AUX_ALARM_CLR_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    DSMC_INIT = 8'h01,
    DSMC_FAULTLESS = 8'h02,
    DSMC_READY = 8'h04,
    DSMC_WAITING = 8'h08,
    DSMC_RUNNING = 8'h10,
    DSMC_QUICK_STOP = 8'h20,
    DSMC_FAULT_STOP = 8'h40,
    DSMC_FAULT = 8'h80
  } dsmc_state_t;

  // True for any object index inside the gain group, read or write
  function automatic logic dsmc_is_gain(input logic [15:0] idx);
    return (idx >= OBJ_GAIN_FIRST) && (idx <= OBJ_GAIN_LAST);
  endfunction

endpackage

// ===== core/dsmc_link_if.sv
// Interface joining the fieldbus controller end and the drive end
`timescale 1ns/1ps
interface dsmc_link_if (
  input wire logic aclk,
  input wire logic aresetn
);
  // Object access request, one-cycle pulse
  logic req_valid;
  logic req_write;
  logic [15:0] req_index;
  logic [7:0] req_sub;
  logic [31:0] req_wdata;
  // Object access answer, one-cycle pulse
  logic rsp_valid;
  logic rsp_err;
  logic [31:0] rsp_rdata;
  // Live status word and its change event
  logic [15:0] status_word;
  logic status_event;
  // Auxiliary functions
  logic trial_run_function;
  logic alarm_clear_function;

  modport drive (
    input aclk, aresetn, req_valid, req_write, req_index, req_sub, req_wdata,
    input trial_run_function, alarm_clear_function,
    output rsp_valid, rsp_err, rsp_rdata, status_word, status_event
  );
  modport master (
    input aclk, aresetn, rsp_valid, rsp_err, rsp_rdata, status_word, status_event,
    output req_valid, req_write, req_index, req_sub, req_wdata,
    output trial_run_function, alarm_clear_function
  );
endinterface

// ===== core/dsmc_drive.sv
// Drive end: power state machine, restore objects and alarm latch
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module dsmc_drive (
  // Link to the controller
  dsmc_link_if.drive link,
  // Drive-side conditions
  input wire logic fault_in,
  input wire logic restart,
  input wire logic homing_done,
  // Drive-side effects
  output logic axis_enable,
  output logic brake_on,
  output logic [3:0] restore_grp,
  output logic alarm_latched,
  output logic trial_active
);
  import dsmc_pkg::*;

  dsmc_state_t state_ff, nxt_state;
  logic [7:0] qs_cnt_ff;
  logic restarted_ff;
  logic [3:0] restored_ff;
  logic [15:0] sw_ff;
  logic cw_wr;
  logic [15:0] cw;
  logic key_ok;
  logic [1:0] sub_sel;

  assign cw_wr = link.req_valid && link.req_write && (link.req_index == OBJ_CTRL_WORD);
  assign cw = link.req_wdata[15:0];
  assign key_ok = link.req_wdata == RESTORE_KEY;
  assign sub_sel = 2'(link.req_sub - 8'h01);

  // ----------------
  // Alarm latch
  // ----------------
  // Restart only counts once the error itself is gone
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      restarted_ff <= 1'b0;
    end else if (fault_in) begin
      restarted_ff <= 1'b0;
    end else if (restart && alarm_latched) begin
      restarted_ff <= 1'b1;
    end
  end

  // A fresh fault wins over a clear in the same cycle
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      alarm_latched <= 1'b0;
    end else if (fault_in) begin
      alarm_latched <= 1'b1;
    end else if (link.alarm_clear_function && restarted_ff) begin
      alarm_latched <= 1'b0; // [R05]
    end
  end

  // ----------------
  // Power state machine
  // ----------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      DSMC_INIT: begin
        nxt_state = fault_in ? DSMC_FAULT_STOP : DSMC_FAULTLESS; // [R07] [R08]
      end
      DSMC_FAULTLESS: begin
        if (cw_wr && cw == CW_SHUTDOWN) begin
          nxt_state = DSMC_READY; // [R09]
        end
      end
      DSMC_READY: begin
        if (cw_wr && cw == CW_SWITCH_ON) begin
          nxt_state = DSMC_WAITING; // [R10]
        end else if (cw_wr && cw == CW_DISABLE) begin
          nxt_state = DSMC_FAULTLESS; // [R12]
        end
      end
      DSMC_WAITING: begin
        if (cw_wr && cw == CW_ENABLE) begin
          nxt_state = DSMC_RUNNING; // [R11]
        end else if (cw_wr && cw == CW_SHUTDOWN) begin
          nxt_state = DSMC_READY; // [R09]
        end else if (cw_wr && cw == CW_DISABLE) begin
          nxt_state = DSMC_FAULTLESS; // [R12]
        end
      end
      DSMC_RUNNING: begin
        if (cw_wr && cw == CW_SWITCH_ON) begin
          nxt_state = DSMC_WAITING; // [R10]
        end else if (cw_wr && cw == CW_SHUTDOWN) begin
          nxt_state = DSMC_READY; // [R09]
        end else if (cw_wr && cw == CW_DISABLE) begin
          nxt_state = DSMC_FAULTLESS; // [R12]
        end else if (cw_wr && cw == CW_QUICK_STOP) begin
          nxt_state = DSMC_QUICK_STOP; // [R13]
        end
      end
      DSMC_QUICK_STOP: begin
        if (cw_wr && cw == CW_ENABLE) begin
          nxt_state = DSMC_RUNNING; // [R13]
        end else if (qs_cnt_ff == QS_CYCLES) begin
          nxt_state = DSMC_FAULTLESS; // [R13]
        end
      end
      DSMC_FAULT_STOP: begin
        if (!alarm_latched) begin
          nxt_state = DSMC_FAULT; // [R14]
        end
      end
      DSMC_FAULT: begin
        if (cw_wr && cw == CW_FAULT_RESET) begin
          nxt_state = DSMC_FAULTLESS; // [R15]
        end
      end
      default: nxt_state = DSMC_FAULT_STOP;
    endcase
    // Any other word leaves the state alone; a fault overrides all
    if (fault_in && state_ff != DSMC_FAULT_STOP) begin
      nxt_state = DSMC_FAULT_STOP; // [R14]
    end
  end

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      state_ff <= DSMC_INIT; // [R07]
    end else begin
      state_ff <= nxt_state; // [R19]
    end
  end

  // Quick stop ramp timer
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn || state_ff != DSMC_QUICK_STOP) begin
      qs_cnt_ff <= 8'h00;
    end else begin
      qs_cnt_ff <= qs_cnt_ff + 8'h01;
    end
  end

  // ----------------
  // Status word and drive outputs
  // ----------------
  function automatic logic [15:0] dsmc_sw(input dsmc_state_t s, input logic homed);
    unique case (s)
      DSMC_INIT: return SW_INIT;
      DSMC_FAULTLESS: return SW_FAULTLESS;
      DSMC_READY: return SW_READY;
      DSMC_WAITING: return SW_WAITING;
      DSMC_RUNNING: return SW_RUNNING | (16'(homed) << SW_HOMED_BIT);
      DSMC_QUICK_STOP: return SW_QUICK_STOP;
      DSMC_FAULT_STOP: return SW_FAULT_STOP;
      DSMC_FAULT: return SW_FAULT;
      default: return SW_FAULT_STOP;
    endcase
  endfunction

  // Registered so status follows the state one edge later
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      sw_ff <= SW_INIT;
      link.status_event <= 1'b0;
    end else begin
      sw_ff <= dsmc_sw(state_ff, homing_done); // [R17]
      link.status_event <= sw_ff != dsmc_sw(state_ff, homing_done); // [R17]
    end
  end
  assign link.status_word = sw_ff;

  // Axis is powered only while running or ramping down
  assign axis_enable = state_ff inside {DSMC_RUNNING, DSMC_QUICK_STOP};
  assign brake_on = !axis_enable; // [R07]
  assign trial_active = link.trial_run_function && !axis_enable;

  // ----------------
  // Object access and restore commands
  // ----------------
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      restored_ff <= 4'h0;
      restore_grp <= 4'h0;
      link.rsp_valid <= 1'b0;
      link.rsp_err <= 1'b0;
      link.rsp_rdata <= 32'h0000_0000;
    end else begin
      restore_grp <= 4'h0;
      link.rsp_valid <= link.req_valid;
      link.rsp_err <= 1'b0;
      link.rsp_rdata <= 32'h0000_0000;
      if (link.req_valid) begin
        if (link.req_index == OBJ_RESTORE && link.req_sub >= 8'h01
            && link.req_sub <= 8'h04) begin
          if (!link.req_write) begin
            link.rsp_rdata <= {31'h0, restored_ff[sub_sel]}; // [R01] [R02] [R03] [R04]
          end else if (key_ok) begin
            restore_grp[sub_sel] <= 1'b1; // [R01] [R02] [R03] [R04]
            restored_ff[sub_sel] <= 1'b1;
          end else begin
            link.rsp_err <= 1'b1;
          end
        end else if (link.req_index == OBJ_SUPPORTED_MODES && !link.req_write) begin
          link.rsp_rdata <= SUPPORTED_MODES_VAL; // [R16]
        end else if (link.req_index == OBJ_STATUS_WORD && !link.req_write) begin
          link.rsp_rdata <= {16'h0, sw_ff}; // [R17]
        end else if (link.req_index != OBJ_CTRL_WORD || !link.req_write) begin
          link.rsp_err <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== core/dsmc_master.sv
// Controller end: AXI4-Lite registers turned into object accesses
`timescale 1ns/1ps
module dsmc_master (
  // AXI4-Lite slave
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link to the drive
  dsmc_link_if.master link
);
  import dsmc_pkg::*;

  logic aw_ff, w_ff, busy_ff, err_ff, trial_ff;
  logic [5:0] awaddr_ff;
  logic [31:0] wdata_ff, obj_addr_ff, obj_wdata_ff, obj_rdata_ff;
  logic wr_go, issue, refuse;

  // ----------------
  // Write channels: address and data taken in either order
  // ----------------
  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ff && !s_axi_bvalid;
  assign wr_go = aw_ff && w_ff && !s_axi_bvalid;
  // Control word or object commands while one is open, or gain writes in a trial, get SLVERR
  assign issue = wr_go && (awaddr_ff == REG_CTRL_WORD || awaddr_ff == REG_OBJ_CMD);
  assign refuse = issue && (busy_ff || (trial_ff && awaddr_ff == REG_OBJ_CMD
                  && wdata_ff[0] && dsmc_is_gain(obj_addr_ff[23:8]))); // [R06]

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 6'h00;
      wdata_ff <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= refuse ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Software registers; strobes ignored, every write is full word
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      obj_addr_ff <= 32'h0000_0000;
      obj_wdata_ff <= 32'h0000_0000;
      trial_ff <= 1'b0;
      link.alarm_clear_function <= 1'b0;
    end else begin
      link.alarm_clear_function <= 1'b0;
      if (wr_go && awaddr_ff == REG_OBJ_ADDR) begin
        obj_addr_ff <= wdata_ff;
      end
      if (wr_go && awaddr_ff == REG_OBJ_WDATA) begin
        obj_wdata_ff <= wdata_ff;
      end
      if (wr_go && awaddr_ff == REG_AUX) begin
        // Trial may only start while the status word is not SW_RUNNING
        trial_ff <= wdata_ff[AUX_TRIAL_BIT] && (trial_ff
                    || link.status_word != SW_RUNNING); // [R06]
        link.alarm_clear_function <= wdata_ff[AUX_ALARM_CLR_BIT];
      end
    end
  end
  assign link.trial_run_function = trial_ff;

  // ----------------
  // Object request toward the drive, one open at a time
  // ----------------
  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      link.req_valid <= 1'b0;
      link.req_write <= 1'b0;
      link.req_index <= 16'h0000;
      link.req_sub <= 8'h00;
      link.req_wdata <= 32'h0000_0000;
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      obj_rdata_ff <= 32'h0000_0000;
    end else begin
      link.req_valid <= 1'b0;
      if (issue && !refuse) begin
        link.req_valid <= 1'b1;
        busy_ff <= 1'b1;
        if (awaddr_ff == REG_CTRL_WORD) begin
          link.req_write <= 1'b1;
          link.req_index <= OBJ_CTRL_WORD;
          link.req_sub <= 8'h00;
          link.req_wdata <= {16'h0, wdata_ff[15:0]};
        end else begin
          link.req_write <= wdata_ff[0];
          link.req_index <= obj_addr_ff[23:8];
          link.req_sub <= obj_addr_ff[7:0];
          link.req_wdata <= obj_wdata_ff;
        end
      end else if (link.rsp_valid) begin
        busy_ff <= 1'b0;
        err_ff <= link.rsp_err;
        obj_rdata_ff <= link.rsp_rdata;
      end
    end
  end

  // ----------------
  // Read channel: answer one cycle after the address is taken
  // ----------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge link.aclk) begin
    if (!link.aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case ({s_axi_araddr[5:2], 2'b00})
        REG_STATUS: s_axi_rdata <= {16'h0, link.status_word}; // [R17] [R18]
        REG_OBJ_ADDR: s_axi_rdata <= obj_addr_ff;
        REG_OBJ_WDATA: s_axi_rdata <= obj_wdata_ff;
        REG_OBJ_RDATA: s_axi_rdata <= obj_rdata_ff;
        REG_AUX: s_axi_rdata <= {31'h0, trial_ff};
        REG_FLAGS: s_axi_rdata <= {29'h0, trial_ff, err_ff, busy_ff};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ===== bench/dsmc_link_assertions.sv
// Checker of the link between the controller end and the drive end
`timescale 1ns/1ps
module dsmc_link_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Object requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_index,
  input wire logic [31:0] req_wdata,
  // Answers and status
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [31:0] rsp_rdata,
  input wire logic [15:0] status_word,
  input wire logic status_event
);
  import dsmc_pkg::*;
  // ----------------
  // Shared sequences
  // ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Homed bit masked off to match the state
  localparam logic [15:0] MASK = 16'hefff;
  sequence cw_req(logic [15:0] w);
    req_valid && req_write && req_index == OBJ_CTRL_WORD && req_wdata[15:0] == w;
  endsequence
  sequence in_state(logic [15:0] s);
    (status_word & MASK) == s;
  endsequence
  // Status follows two or three edges after the word is seen
  property cw_moves(logic [15:0] w, logic [15:0] from, logic [15:0] to);
    cw_req(w) ##0 in_state(from) |-> ##[2:3] in_state(to);
  endproperty
  // ----------------
  // Assertions
  // ----------------
  rsp_timing_a: assert property (req_valid |=> rsp_valid)
    else $error("answer missing");
  rsp_cause_a: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without request");
  event_on_change_a: assert property ($changed(status_word & MASK) |-> status_event)
    else $error("state change without event");
  event_cause_a: assert property (status_event |-> $changed(status_word))
    else $error("event without change");
  modes_read_a: assert property (req_valid && !req_write && req_index == OBJ_SUPPORTED_MODES
    |=> rsp_rdata == 32'h0000_03ad && !rsp_err) else $error("supported modes wrong");
  power_up_a: assert property ($rose(aresetn) |-> status_word == SW_INIT ##[1:2]
    (status_word == SW_FAULTLESS || status_word == SW_FAULT_STOP)) else $error("power-up");
  shutdown_a: assert property (cw_moves(CW_SHUTDOWN, SW_FAULTLESS, SW_READY))
    else $error("shutdown");
  switch_on_a: assert property (cw_moves(CW_SWITCH_ON, SW_READY, SW_WAITING))
    else $error("switch on");
  enable_a: assert property (cw_moves(CW_ENABLE, SW_WAITING, SW_RUNNING))
    else $error("enable");
  disable_a: assert property (cw_moves(CW_DISABLE, SW_RUNNING, SW_FAULTLESS))
    else $error("disable");
  quick_stop_a: assert property (cw_moves(CW_QUICK_STOP, SW_RUNNING, SW_QUICK_STOP))
    else $error("quick stop");
  qs_resume_a: assert property (cw_moves(CW_ENABLE, SW_QUICK_STOP, SW_RUNNING))
    else $error("resume");
  qs_fallback_a: assert property ($rose(status_word == SW_QUICK_STOP)
    |-> ##[1:30] status_word != SW_QUICK_STOP) else $error("quick stop stuck");
  fault_reset_a: assert property (cw_moves(CW_FAULT_RESET, SW_FAULT, SW_FAULTLESS))
    else $error("fault reset");
  invalid_hold_a: assert property (cw_req(CW_ENABLE) ##0 in_state(SW_FAULTLESS)
    |=> $stable(status_word)[*3]) else $error("invalid word moved state");
  ctrl_read_a: assert property (req_valid && !req_write && req_index == OBJ_CTRL_WORD
    |=> rsp_err) else $error("control word read accepted");
endmodule

// ===== bench/drive_state_machine_ctrl_test.sv
// Self-checking testbench joining the controller and drive ends
`timescale 1ns/1ps
module drive_state_machine_ctrl_test;
  import dsmc_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [5:0] awaddr = 0;
  logic [5:0] araddr = 0;
  logic [31:0] wdata = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic fault_in = 0, restart = 0, homing_done = 0;
  logic axis_enable, brake_on, alarm_latched, trial_active;
  logic [3:0] restore_grp;
  logic [3:0] grp_last = 0;
  int err_total = 0, checked = 0, cycles = 0;
  // Control word and resulting status, one pair per step
  localparam logic [31:0] SEQ [24] = '{
    32'h000f0250, 32'h00800250, 32'h00060231, 32'h00070233, 32'h000f0237, 32'h00060231,
    32'h00070233, 32'h000f0237, 32'h00070233, 32'h00060231, 32'h00000250, 32'h00060231,
    32'h00070233, 32'h00000250, 32'h00060231, 32'h00070233, 32'h000f0237, 32'h00000250,
    32'h00060231, 32'h00070233, 32'h000f0237, 32'h00020217, 32'h000f0237, 32'h00020217};
  // ----------------
  // Design, link and checker
  // ----------------
  dsmc_link_if link (.aclk(aclk), .aresetn(aresetn));
  dsmc_master dsmc_master_inst (.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(link));
  dsmc_drive dsmc_drive_inst (.link(link), .fault_in(fault_in), .restart(restart),
    .homing_done(homing_done), .axis_enable(axis_enable), .brake_on(brake_on),
    .restore_grp(restore_grp), .alarm_latched(alarm_latched), .trial_active(trial_active));
  dsmc_link_assertions dsmc_link_assertions_inst (.aclk(aclk), .aresetn(aresetn),
    .req_valid(link.req_valid), .req_write(link.req_write), .req_index(link.req_index),
    .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid), .rsp_err(link.rsp_err),
    .rsp_rdata(link.rsp_rdata), .status_word(link.status_word),
    .status_event(link.status_event));
  // Clock, hang guard, capture of the one-cycle restore pulse
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (restore_grp != 4'h0) grp_last <= restore_grp;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // ----------------
  // Shared tasks
  // ----------------
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Address and data offered together; each dropped once taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er), "write response");
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] x, input string what,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, x, what);
    chk(32'(rresp), 32'(er), "read response");
  endtask
  task automatic cw(input logic [15:0] w, input logic [15:0] s);
    wr(REG_CTRL_WORD, {16'h0, w});
    repeat (4) @(posedge aclk);
    rd(REG_STATUS, 32'(s), "status word");
  endtask
  task automatic obj(input logic [15:0] i, input logic [7:0] s, input logic w,
                     input logic [31:0] d, input logic e, input logic [31:0] x);
    wr(REG_OBJ_ADDR, {8'h0, i, s});
    wr(REG_OBJ_WDATA, d);
    wr(REG_OBJ_CMD, {31'h0, w});
    repeat (4) @(posedge aclk);
    rd(REG_FLAGS, {30'h0, e, 1'b0}, "object error");
    if (!w && !e) rd(REG_OBJ_RDATA, x, "object data");
  endtask
  // Fault gone, restart, then clear: the only way out of fault stop
  task automatic recover;
    fault_in <= 1'b0;
    wr(REG_AUX, 32'h2);
    @(posedge aclk); // A wrong clear lands at the edge the write ends
    chk(32'(alarm_latched), 32'h1, "alarm before restart");
    restart <= 1'b1;
    @(posedge aclk);
    restart <= 1'b0;
    wr(REG_AUX, 32'h2);
    cw(CW_SHUTDOWN, SW_FAULT);
    cw(CW_FAULT_RESET, SW_FAULTLESS);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_power;
    @(posedge aclk); // Status lags the state by one edge
    rd(REG_STATUS, 32'(SW_FAULTLESS), "after reset");
    chk(32'(brake_on), 32'h1, "brake");
    obj(OBJ_SUPPORTED_MODES, 8'h0, 1'b0, 32'h0, 1'b0, 32'h0000_03ad);
    obj(OBJ_CTRL_WORD, 8'h0, 1'b0, 32'h0, 1'b1, 32'h0);
    rd(6'h20, 32'h0, "unmapped read", RESP_SLVERR);
    wr(6'h24, 32'h5);
    $display("test power-up done");
  endtask
  task automatic t_states;
    for (int k = 0; k < 24; k++) cw(SEQ[k][31:16], SEQ[k][15:0]);
    chk(32'(axis_enable), 32'h1, "axis in quick stop");
    repeat (int'(QS_CYCLES) + 4) @(posedge aclk);
    rd(REG_STATUS, 32'(SW_FAULTLESS), "quick stop end");
    chk(32'(brake_on), 32'h1, "brake after stop");
    $display("test state machine done");
  endtask
  task automatic t_homing_fault;
    cw(CW_SHUTDOWN, SW_READY);
    cw(CW_SWITCH_ON, SW_WAITING);
    homing_done <= 1'b1;
    cw(CW_ENABLE, SW_RUNNING | 16'h1000);
    homing_done <= 1'b0;
    fault_in <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(32'(axis_enable), 32'h0, "axis in fault");
    cw(CW_FAULT_RESET, SW_FAULT_STOP);
    recover();
    $display("test homing and fault done");
  endtask
  task automatic t_restore;
    for (int s = 1; s <= 4; s++) begin
      obj(OBJ_RESTORE, 8'(s), 1'b0, 32'h0, 1'b0, 32'h0);
      obj(OBJ_RESTORE, 8'(s), 1'b1, 32'h646f616c, 1'b1, 32'h0);
      chk(32'(grp_last), (s == 1) ? 32'h0 : 32'h1 << (s - 2), "wrong key");
      obj(OBJ_RESTORE, 8'(s), 1'b1, 32'h64616f6c, 1'b0, 32'h0);
      chk(32'(grp_last), 32'h1 << (s - 1), "restore group");
      obj(OBJ_RESTORE, 8'(s), 1'b0, 32'h0, 1'b0, 32'h1);
    end
    $display("test restore done");
  endtask
  task automatic t_trial_init;
    wr(REG_AUX, 32'h1);
    chk(32'(trial_active), 32'h1, "trial on");
    wr(REG_OBJ_ADDR, {8'h0, OBJ_GAIN_FIRST, 8'h0});
    wr(REG_OBJ_CMD, 32'h1, RESP_SLVERR);
    wr(REG_AUX, 32'h0);
    chk(32'(trial_active), 32'h0, "trial off");
    aresetn <= 1'b0;
    fault_in <= 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(REG_STATUS, 32'(SW_FAULT_STOP), "fault at start");
    recover();
    $display("test trial and start fault done");
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_power();
    t_states();
    t_homing_fault();
    t_restore();
    t_trial_init();
    end_sim();
  end
endmodule
